/* File: design/pmbr_regs.svh */
// Register offsets, field positions and reset values of the burst read bridge.
// Assumes a 12-bit APB byte address with one aligned 32-bit word per register.
`ifndef PMBR_REGS_SVH
`define PMBR_REGS_SVH

`define PMBR_ADDR_W 12
`define PMBR_CTRL_OFF 12'h000
`define PMBR_STAT_OFF 12'h004
`define PMBR_DWCNT_OFF 12'h008

`define PMBR_CTRL_EN_BIT 0
`define PMBR_CTRL_RST 1'b1

`define PMBR_STAT_CODE_LSB 0
`define PMBR_STAT_TERM_LSB 4
`define PMBR_STAT_CNT_LSB 8

`define PMBR_CNT_W 16
`define PMBR_DWCNT_RST 32'h00000000

`endif

/* File: design/pmbr_pkg.sv */
// Types shared by the burst read bridge: controller states and the state record.
// Assumes the constants header is compiled alongside.
`include "pmbr_regs.svh"

package pmbr_pkg;

    typedef enum logic [2:0] {
        PMBR_IDLE,
        PMBR_WAIT_GNT,
        PMBR_ALOAD,
        PMBR_ADDR,
        PMBR_DATA,
        PMBR_TURN,
        PMBR_REL
    } pmbr_fsm_type;

    typedef struct packed {
        pmbr_fsm_type fsm;
        logic enable;
        logic apb_ready;
        logic apb_err;
        logic [31:0] prdata;
        logic reqn;
        logic framen;
        logic framen_oe;
        logic req64n;
        logic irdyn;
        logic irdyn_oe;
        logic [31:0] ad_out;
        logic ad_oe;
        logic [3:0] cben_out;
        logic cben_oe;
        logic [31:0] addr;
        logic [3:0] cmd;
        logic [`PMBR_CNT_W-1:0] len;
        logic [`PMBR_CNT_W-1:0] count;
        logic half;
        logic [63:0] rdata;
        logic low_n;
        logic high_n;
        logic [3:0] state_code;
        logic [3:0] term;
        logic [31:0] dw_count;
    } pmbr_state_type;

endpackage : pmbr_pkg

/* File: design/pmbr_bridge.sv */
// PCI 32-bit master burst read bridge feeding a 64-bit local read bus, with an APB register port.
// Assumes PCI pins resolved outside from the output enables and all inputs synchronous to pclk.
//
// Notes on behaviour
// RULE1: Each completed DWORD goes to the local read bus, odd ones on [31:0], even ones on [63:32], and the count drops.
// RULE2: One cycle after target and local ready were both asserted, the strobe of the new half asserts and the other clears; code: irdy, not local ready.
// RULE3: The local master captures the indicated half while its strobe is asserted and advances its own address.
// RULE4: Initiator ready is asserted in every cycle that follows a cycle with the local ready asserted; code: only in data phases, not after the last.
// RULE5: In the last data phase of the burst, frame and the 64-bit request are deasserted.
// RULE6: A data phase completes when initiator and target ready are both asserted, and each moves exactly one DWORD.
// RULE7: Forwarding the final DWORD brings the burst counter to zero.
// RULE8: After the final phase frame, req64 and byte enables are released, irdy deasserts, status reads normal termination.
// RULE9: The target keeps target ready asserted and drives the next DWORD while it can supply data.
// RULE10: In the turnaround the target releases the address/data lines and deasserts devsel and target ready.
// RULE11: The local master holds its ready while it can accept and drops it once the burst is read.
// RULE12: In the idle cycle after the turnaround, irdy is released and both strobes deassert.
// RULE13: The local master starts with its 32-bit request together with address, command and burst length.
// RULE14: In the address phase the burst counter loads the burst length given with the request.
// RULE15: Status and termination codes are parameters of the design.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/10ps

module pmbr_bridge #(
    parameter int CNT_W = 16,
    parameter logic [3:0] ST_IDLE = 4'h0, // [RULE15]
    parameter logic [3:0] ST_ALOAD = 4'h1, // [RULE15]
    parameter logic [3:0] ST_TRANS = 4'h2, // [RULE15]
    parameter logic [3:0] ST_TERM = 4'h3, // [RULE15]
    parameter logic [3:0] TERM_NONE = 4'h0, // [RULE15]
    parameter logic [3:0] TERM_NORMAL = 4'h1 // [RULE15]
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PMBR_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic gntn,
    output logic reqn,
    output logic framen_out,
    output logic framen_oe,
    output logic req64n_out,
    output logic req64n_oe,
    output logic irdyn_out,
    output logic irdyn_oe,
    input wire logic trdyn,
    input wire logic [31:0] ad_in,
    output logic [31:0] ad_out,
    output logic ad_oe,
    output logic [3:0] cben_out,
    output logic cben_oe,
    input wire logic narrow_request_n,
    input wire logic [31:0] local_start_addr,
    input wire logic [3:0] local_cmd_byte_en,
    input wire logic [CNT_W-1:0] requested_burst_len,
    input wire logic local_master_ready_n,
    output logic [63:0] local_read_data,
    output logic low_half_xfer_strobe_n,
    output logic high_half_xfer_strobe_n,
    output logic [CNT_W-1:0] burst_remaining_count,
    output logic [3:0] local_master_state_code,
    output logic [3:0] termination_kind
);

    generate
        if (CNT_W < 1 || CNT_W > `PMBR_CNT_W)
        begin : g_bad_cnt_w
            $error("CNT_W must lie between 1 and the status counter field width");
        end
    endgenerate

    localparam pmbr_pkg::pmbr_state_type RST_STATE = '{
        fsm: pmbr_pkg::PMBR_IDLE,
        enable: `PMBR_CTRL_RST,
        reqn: 1'b1,
        framen: 1'b1,
        req64n: 1'b1,
        irdyn: 1'b1,
        low_n: 1'b1,
        high_n: 1'b1,
        state_code: ST_IDLE,
        term: TERM_NONE,
        dw_count: `PMBR_DWCNT_RST,
        default: '0
    };

    pmbr_pkg::pmbr_state_type s_q;
    pmbr_pkg::pmbr_state_type s_d;
    logic phase_done;
    logic last_phase;

    // Completion uses the registered irdy, which is what the target really sees on the wire.
    assign phase_done = (s_q.fsm == pmbr_pkg::PMBR_DATA) && !s_q.irdyn && !trdyn; // [RULE6]
    assign last_phase = (s_q.count <= `PMBR_CNT_W'(1));

    always_comb
    begin
        s_d = s_q;
        if (ce)
        begin
            // APB: two-cycle access, answered at the second access edge.
            if (psel && penable && !s_q.apb_ready)
            begin
                s_d.apb_ready = 1'b1;
                s_d.apb_err = 1'b0;
                s_d.prdata = 32'h00000000;
                unique case (paddr)
                    `PMBR_CTRL_OFF:
                    begin
                        if (pwrite)
                        begin
                            s_d.enable = pwdata[`PMBR_CTRL_EN_BIT];
                        end
                        else
                        begin
                            s_d.prdata[`PMBR_CTRL_EN_BIT] = s_q.enable;
                        end
                    end
                    `PMBR_STAT_OFF:
                    begin
                        s_d.prdata[`PMBR_STAT_CODE_LSB +: 4] = s_q.state_code;
                        s_d.prdata[`PMBR_STAT_TERM_LSB +: 4] = s_q.term;
                        s_d.prdata[`PMBR_STAT_CNT_LSB +: `PMBR_CNT_W] = s_q.count;
                    end
                    `PMBR_DWCNT_OFF:
                    begin
                        s_d.prdata = s_q.dw_count;
                    end
                    default:
                    begin
                        s_d.apb_err = 1'b1;
                    end
                endcase
            end
            else
            begin
                s_d.apb_ready = 1'b0;
                s_d.apb_err = 1'b0;
            end

            unique case (s_q.fsm)
                pmbr_pkg::PMBR_IDLE:
                begin
                    if (s_q.enable && !narrow_request_n)
                    begin
                        s_d.addr = local_start_addr;
                        s_d.cmd = local_cmd_byte_en;
                        s_d.len = `PMBR_CNT_W'(requested_burst_len);
                        s_d.reqn = 1'b0;
                        s_d.term = TERM_NONE;
                        s_d.fsm = pmbr_pkg::PMBR_WAIT_GNT;
                    end
                end
                pmbr_pkg::PMBR_WAIT_GNT:
                begin
                    if (!gntn)
                    begin
                        s_d.state_code = ST_ALOAD;
                        s_d.fsm = pmbr_pkg::PMBR_ALOAD;
                    end
                end
                pmbr_pkg::PMBR_ALOAD:
                begin
                    s_d.framen = 1'b0;
                    s_d.framen_oe = 1'b1;
                    s_d.req64n = 1'b0;
                    s_d.ad_out = s_q.addr;
                    s_d.ad_oe = 1'b1;
                    s_d.cben_out = s_q.cmd;
                    s_d.cben_oe = 1'b1;
                    s_d.count = s_q.len; // [RULE14]
                    s_d.half = 1'b0;
                    s_d.reqn = 1'b1;
                    s_d.state_code = ST_TRANS;
                    s_d.fsm = pmbr_pkg::PMBR_ADDR;
                end
                pmbr_pkg::PMBR_ADDR:
                begin
                    s_d.ad_oe = 1'b0;
                    s_d.cben_out = local_cmd_byte_en;
                    s_d.irdyn = local_master_ready_n; // [RULE4]
                    s_d.irdyn_oe = 1'b1;
                    // A one-word burst has its only phase as the last one.
                    s_d.framen = last_phase; // [RULE5]
                    s_d.req64n = last_phase;
                    s_d.fsm = pmbr_pkg::PMBR_DATA;
                end
                pmbr_pkg::PMBR_DATA:
                begin
                    s_d.cben_out = local_cmd_byte_en;
                    s_d.irdyn = local_master_ready_n; // [RULE4]
                    s_d.low_n = 1'b1;
                    s_d.high_n = 1'b1;
                    if (phase_done)
                    begin
                        // Odd DWORDs land low, even ones high; the strobe drops low with the data.
                        if (!s_q.half)
                        begin
                            s_d.rdata[31:0] = ad_in; // [RULE1]
                            s_d.low_n = 1'b0; // [RULE2]
                        end
                        else
                        begin
                            s_d.rdata[63:32] = ad_in; // [RULE1]
                            s_d.high_n = 1'b0; // [RULE2]
                        end
                        s_d.half = !s_q.half;
                        s_d.count = s_q.count - `PMBR_CNT_W'(1); // [RULE1] [RULE7]
                        s_d.dw_count = s_q.dw_count + 32'h00000001; // [RULE6]
                        if (last_phase)
                        begin
                            s_d.framen_oe = 1'b0; // [RULE8]
                            s_d.framen = 1'b1;
                            s_d.req64n = 1'b1;
                            s_d.cben_oe = 1'b0;
                            s_d.irdyn = 1'b1;
                            s_d.state_code = ST_TERM;
                            s_d.term = TERM_NORMAL;
                            s_d.fsm = pmbr_pkg::PMBR_TURN;
                        end
                        else if (s_q.count == `PMBR_CNT_W'(2))
                        begin
                            s_d.framen = 1'b1; // [RULE5]
                            s_d.req64n = 1'b1;
                        end
                    end
                end
                pmbr_pkg::PMBR_TURN:
                begin
                    s_d.irdyn_oe = 1'b0; // [RULE12]
                    s_d.irdyn = 1'b1;
                    s_d.low_n = 1'b1;
                    s_d.high_n = 1'b1;
                    s_d.fsm = pmbr_pkg::PMBR_REL;
                end
                pmbr_pkg::PMBR_REL:
                begin
                    // One idle cycle keeps back-to-back bursts from overlapping the release.
                    s_d.fsm = pmbr_pkg::PMBR_IDLE;
                end
                default:
                begin
                    s_d.fsm = pmbr_pkg::PMBR_IDLE;
                end
            endcase
            // DWORD counter write clears it, unless a DWORD lands in the same cycle.
            if (psel && penable && !s_q.apb_ready && pwrite && paddr == `PMBR_DWCNT_OFF && !phase_done)
            begin
                s_d.dw_count = `PMBR_DWCNT_RST;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= RST_STATE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.apb_ready;
    assign pslverr = s_q.apb_err;
    assign reqn = s_q.reqn;
    assign framen_out = s_q.framen;
    assign framen_oe = s_q.framen_oe;
    assign req64n_out = s_q.req64n;
    assign req64n_oe = s_q.framen_oe;
    assign irdyn_out = s_q.irdyn;
    assign irdyn_oe = s_q.irdyn_oe;
    assign ad_out = s_q.ad_out;
    assign ad_oe = s_q.ad_oe;
    assign cben_out = s_q.cben_out;
    assign cben_oe = s_q.cben_oe;
    assign local_read_data = s_q.rdata;
    assign low_half_xfer_strobe_n = s_q.low_n;
    assign high_half_xfer_strobe_n = s_q.high_n;
    assign burst_remaining_count = s_q.count[CNT_W-1:0];
    assign local_master_state_code = s_q.state_code;
    assign termination_kind = s_q.term;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_low_half_xfer: assert property (ce && phase_done && !s_q.half |=> // [RULE1] [RULE2]
        !low_half_xfer_strobe_n && high_half_xfer_strobe_n && local_read_data[31:0] == $past(ad_in))
        else $error("low half transfer wrong");
    a_high_half_xfer: assert property (ce && phase_done && s_q.half |=> // [RULE1] [RULE2]
        low_half_xfer_strobe_n && !high_half_xfer_strobe_n && local_read_data[63:32] == $past(ad_in))
        else $error("high half transfer wrong");
    a_count_per_phase: assert property (ce && phase_done |=> s_q.count == $past(s_q.count) - `PMBR_CNT_W'(1)) // [RULE6]
        else $error("burst counter did not drop by one");
    a_no_phase_hold: assert property (ce && !phase_done |=> s_q.count == $past(s_q.count) || $past(s_q.fsm) == pmbr_pkg::PMBR_ALOAD) // [RULE6]
        else $error("burst counter moved without a phase");
    a_irdy_follow: assert property (ce && s_q.fsm == pmbr_pkg::PMBR_DATA && !local_master_ready_n && !(phase_done && last_phase) // [RULE4]
        |=> !irdyn_out && irdyn_oe)
        else $error("irdy not asserted after local ready");
    a_frame_last: assert property (ce && phase_done && s_q.count == `PMBR_CNT_W'(2) |=> framen_out && req64n_out) // [RULE5]
        else $error("frame not dropped for last phase");
    a_burst_end: assert property (ce && phase_done && last_phase |=> burst_remaining_count == '0 && !framen_oe // [RULE7] [RULE8]
        && !cben_oe && irdyn_out && irdyn_oe && local_master_state_code == ST_TERM && termination_kind == TERM_NORMAL)
        else $error("burst end not signalled");
    a_idle_release: assert property (ce && s_q.fsm == pmbr_pkg::PMBR_TURN |=> !irdyn_oe && low_half_xfer_strobe_n // [RULE12]
        && high_half_xfer_strobe_n)
        else $error("irdy or strobes not released");
    a_load_count: assert property (ce && s_q.fsm == pmbr_pkg::PMBR_ALOAD |=> s_q.count == $past(s_q.len) // [RULE14]
        && local_master_state_code == ST_TRANS && !framen_out)
        else $error("burst counter not loaded");

endmodule : pmbr_bridge

/* File: tb/pmbr_pci_target.sv */
// Behavioural PCI target for the burst read bridge: answers each data phase with a counted DWORD.
// Assumes one pclk domain and that the bridge drives frame, irdy and the address phase enable.
`timescale 1ns/10ps

module pmbr_pci_target (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic framen_out,
    input wire logic framen_oe,
    input wire logic irdyn_out,
    input wire logic ad_oe,
    input wire logic stall,
    output logic trdyn,
    output logic [31:0] ad_in
);
    logic active;
    logic [15:0] k;

    // Released lines toggle each cycle between the last value and its inverse, so the last data word returns every other cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            active <= 1'b0;
            k <= 16'h0000;
            trdyn <= 1'b1;
            ad_in <= 32'h00000000;
        end
        else if (!active)
        begin
            if (framen_oe && !framen_out && ad_oe)
            begin
                active <= 1'b1;
                k <= 16'h0001;
                trdyn <= stall;
                ad_in <= 32'hDA7A0001;
            end
            else
                ad_in <= ~ad_in;
        end
        else if (!irdyn_out && !trdyn)
        begin
            if (framen_out)
            begin
                active <= 1'b0;
                trdyn <= 1'b1;
                ad_in <= ~ad_in;
            end
            else
            begin
                k <= k + 16'h0001;
                trdyn <= stall;
                ad_in <= {16'hDA7A, k + 16'h0001};
            end
        end
        else
            trdyn <= stall;
    end
endmodule : pmbr_pci_target

/* File: tb/pmbr_bridge_test.sv */
// Self-checking bench for the burst read bridge: APB register access and PCI bursts read by a local master.
// Assumes the bridge package, constants header and target model are compiled before it.
`timescale 1ns/10ps
`include "pmbr_regs.svh"

module pmbr_bridge_test;
    localparam logic [3:0] ST_TERM = 4'h3;
    localparam logic [3:0] TERM_NORMAL = 4'h1;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, gntn = 1'b1, ce = 1'b1;
    logic narrow_request_n = 1'b1, local_master_ready_n = 1'b1, busy = 1'b0, slow = 1'b0, prev_rdy = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, local_start_addr = 32'h00000000, prdata, ad_in, ad_out, rd;
    logic [3:0] local_cmd_byte_en = 4'h0, cben_out, local_master_state_code, termination_kind;
    logic [15:0] requested_burst_len = 16'h0000, burst_remaining_count;
    logic [63:0] local_read_data;
    logic [2:0] cyc = 3'h0;
    logic pready, pslverr, reqn, framen_out, framen_oe, req64n_out, req64n_oe, irdyn_out, irdyn_oe, trdyn;
    logic ad_oe, cben_oe, low_half_xfer_strobe_n, high_half_xfer_strobe_n, err;
    int n_fail = 0, num_checks = 0, k = 0, ph = 0, exp_len = 0;

    pmbr_bridge #(.ST_TERM(ST_TERM), .TERM_NORMAL(TERM_NORMAL)) uut (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .gntn(gntn), .reqn(reqn), .framen_out(framen_out),
        .framen_oe(framen_oe), .req64n_out(req64n_out), .req64n_oe(req64n_oe), .irdyn_out(irdyn_out),
        .irdyn_oe(irdyn_oe), .trdyn(trdyn), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .cben_out(cben_out),
        .cben_oe(cben_oe), .narrow_request_n(narrow_request_n), .local_start_addr(local_start_addr),
        .local_cmd_byte_en(local_cmd_byte_en), .requested_burst_len(requested_burst_len),
        .local_master_ready_n(local_master_ready_n), .local_read_data(local_read_data),
        .low_half_xfer_strobe_n(low_half_xfer_strobe_n), .high_half_xfer_strobe_n(high_half_xfer_strobe_n),
        .burst_remaining_count(burst_remaining_count), .local_master_state_code(local_master_state_code),
        .termination_kind(termination_kind));

    pmbr_pci_target target (.pclk(pclk), .presetn(presetn), .framen_out(framen_out), .framen_oe(framen_oe),
        .irdyn_out(irdyn_out), .ad_oe(ad_oe), .stall(slow && cyc[1:0] == 2'h2), .trdyn(trdyn), .ad_in(ad_in));

    always #10 pclk = ~pclk;

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        num_checks++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            n_fail++;
        end
    endtask : chk

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] d,
        output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("apb wait", 1'b0, n >= 20);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic apb_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000, rd, err);
        chk("prdata", exp, rd);
    endtask : apb_chk

    task automatic burst(input int len, input logic s);
        int n;
        n = 0;
        exp_len = len;
        k = 0;
        ph = 0;
        slow <= s;
        busy <= 1'b1;
        narrow_request_n <= 1'b0;
        local_start_addr <= 32'h00001000;
        local_cmd_byte_en <= 4'h6;
        requested_burst_len <= len[15:0];
        @(posedge pclk);
        while (reqn !== 1'b0 && n < 50)
        begin
            @(posedge pclk);
            n++;
        end
        narrow_request_n <= 1'b1;
        gntn <= 1'b0;
        while (termination_kind !== TERM_NORMAL && n < 400)
        begin
            @(posedge pclk);
            n++;
        end
        chk("burst wait", 1'b0, n >= 400);
        chk("state code", ST_TERM, local_master_state_code);
        chk("released", 4'b0010, {framen_oe, req64n_oe, irdyn_out, cben_oe});
        gntn <= 1'b1;
        @(posedge pclk);
        busy <= 1'b0;
        chk("idle", 3'b011, {irdyn_oe, low_half_xfer_strobe_n, high_half_xfer_strobe_n});
        chk("dword total", len, k);
        chk("count end", 16'h0000, burst_remaining_count);
        repeat (2) @(posedge pclk);
    endtask : burst

    // The local master stays ready through a burst, with a periodic hiccup when slow.
    always @(posedge pclk)
    begin
        cyc <= cyc + 3'h1;
        local_master_ready_n <= !(busy && !(slow && cyc == 3'h3));
        prev_rdy <= local_master_ready_n;
    end

    always @(posedge pclk)
    begin
        if (busy && ad_oe === 1'b1)
            chk("address phase", {16'h0000, 32'h00001000, 4'h6, exp_len[11:0]},
                {16'h0000, ad_out, cben_out, burst_remaining_count[11:0]});
        if (busy && framen_oe === 1'b1 && ad_oe === 1'b0 && prev_rdy === 1'b0)
            chk("irdyn", 1'b0, irdyn_out);
        if (busy && framen_oe === 1'b1 && irdyn_out === 1'b0 && trdyn === 1'b0)
        begin
            ph++;
            chk("frame end", ph == exp_len ? 2'b11 : 2'b00, {framen_out, req64n_out});
        end
        if (busy && (low_half_xfer_strobe_n === 1'b0 || high_half_xfer_strobe_n === 1'b0))
        begin
            k++;
            chk("strobes", k[0] ? 2'b01 : 2'b10, {low_half_xfer_strobe_n, high_half_xfer_strobe_n});
            chk("half data", {16'hDA7A, k[15:0]}, k[0] ? local_read_data[31:0] : local_read_data[63:32]);
            chk("count", exp_len - k, burst_remaining_count);
        end
    end

    initial
    begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        results;
    end

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb_chk(`PMBR_CTRL_OFF, 32'h00000001);
        apb_chk(`PMBR_STAT_OFF, 32'h00000000);
        apb_chk(`PMBR_DWCNT_OFF, `PMBR_DWCNT_RST);
        burst(4, 1'b0);
        apb_chk(`PMBR_STAT_OFF, {24'h000000, TERM_NORMAL, ST_TERM});
        burst(5, 1'b1);
        burst(1, 1'b0);
        apb_chk(`PMBR_DWCNT_OFF, 32'h0000000A);
        apb(1'b1, `PMBR_DWCNT_OFF, 32'h00000000, rd, err);
        apb_chk(`PMBR_DWCNT_OFF, 32'h00000000);
        apb(1'b1, `PMBR_STAT_OFF, 32'hFFFFFFFF, rd, err);
        apb_chk(`PMBR_STAT_OFF, {24'h000000, TERM_NORMAL, ST_TERM});
        apb(1'b0, 12'h00C, 32'h00000000, rd, err);
        chk("unmapped", 33'h100000000, {err, rd});
        apb(1'b1, `PMBR_CTRL_OFF, 32'h00000000, rd, err);
        narrow_request_n <= 1'b0;
        repeat (6) @(posedge pclk);
        chk("blocked reqn", 1'b1, reqn);
        narrow_request_n <= 1'b1;
        apb(1'b1, `PMBR_CTRL_OFF, 32'h00000001, rd, err);
        apb_chk(`PMBR_CTRL_OFF, 32'h00000001);
        // With the clock enable low a pending local request must not be taken.
        ce <= 1'b0;
        narrow_request_n <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("frozen reqn", 1'b1, reqn);
        ce <= 1'b1;
        narrow_request_n <= 1'b1;
        @(posedge pclk);
        burst(2, 1'b1);
        results;
    end
endmodule : pmbr_bridge_test
